// ===== verification/acs_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.svh"
module acs_sequencer_tb_top;
  logic        clock_in;
  logic        rst_n_in;
  logic [3:0]  addr_in;
  logic [7:0]  wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [11:0] sar_result_in;
  logic [7:0]  rdata_out;
  logic        irq_out;
  logic        power_enable_out;
  logic        sample_out;
  logic        conversion_clock_out;
  logic        busy_out;
  int          bad_count;
  int          checks_done;
  int          busy_cnt;
  int          samp_cnt;
  int          clk_cnt;
  logic [7:0]  rd_val;

  acs_sequencer u_acs_sequencer (
    .clock_in             (clock_in),
    .rst_n_in             (rst_n_in),
    .addr_in              (addr_in),
    .wdata_in             (wdata_in),
    .wr_in                (wr_in),
    .rd_in                (rd_in),
    .sar_result_in        (sar_result_in),
    .rdata_out            (rdata_out),
    .irq_out              (irq_out),
    .power_enable_out     (power_enable_out),
    .sample_out           (sample_out),
    .conversion_clock_out (conversion_clock_out),
    .busy_out             (busy_out)
  );

  // 20 MHz system clock
  always #25 clock_in = ~clock_in;

  // Count busy and sampling cycles at the falling edge, where outputs are settled
  always @(negedge clock_in) begin
    if (busy_out === 1'b1) busy_cnt++;
    if (sample_out === 1'b1) samp_cnt++;
    if (conversion_clock_out === 1'b1) clk_cnt++;
  end

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // A gap cycle after each strobe keeps a driver from assigning twice in one step
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
    @(posedge clock_in);
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
    @(posedge clock_in);
  endtask : bus_rd

  task automatic test_reset_values();
    bus_rd(`ACS_ADDR_CTRL, rd_val);
    chk("ctrl after reset", {4'h0, rd_val}, 12'h000);
    chk("irq after reset", {11'h000, irq_out}, 12'h000);
    bus_rd(4'hF, rd_val);
    chk("unmapped read", {4'h0, rd_val}, 12'h000);
  endtask : test_reset_values

  task automatic test_power_off_start();
    busy_cnt = 0;
    bus_wr(`ACS_ADDR_CTRL, 8'h01);
    bus_wr(`ACS_ADDR_CTRL, 8'h00);
    repeat (40) @(posedge clock_in);
    chk("busy cycles power off", busy_cnt[11:0], 12'h000);
    chk("power output off", {11'h000, power_enable_out}, 12'h000);
  endtask : test_power_off_start

  // One conversion at one divider code, with or without the interrupt enabled
  task automatic test_conversion(input logic [2:0] div, input logic en);
    logic [11:0] res;
    res = (div == 3'h7) ? 12'hFFF : (12'h5A0 + {9'h000, div});
    sar_result_in <= res;
    bus_wr(`ACS_ADDR_CLKDIV, {5'h00, div});
    bus_wr(`ACS_ADDR_IRQ_EN, {7'h00, en});
    bus_wr(`ACS_ADDR_CTRL, 8'h03);
    chk("power output on", {11'h000, power_enable_out}, 12'h001);
    // Settling time after power up before the first start
    repeat (8) @(posedge clock_in);
    busy_cnt = 0;
    samp_cnt = 0;
    clk_cnt  = 0;
    bus_wr(`ACS_ADDR_CTRL, 8'h02);
    chk("busy after start", {11'h000, busy_out}, 12'h001);
    bus_rd(`ACS_ADDR_CTRL, rd_val);
    chk("ctrl while busy", {4'h0, rd_val}, 12'h082);
    // Interrupt runs watch the busy_out pin; the others poll busy over the bus
    for (int i = 0; i < 2100 && (en ? busy_out : rd_val[7]) !== 1'b0; i++) begin
      if (en) begin
        @(negedge clock_in);
      end else begin
        bus_rd(`ACS_ADDR_CTRL, rd_val);
      end
    end
    chk("busy cleared", {11'h000, busy_out}, 12'h000);
    chk("busy length", busy_cnt[11:0], 12'h010 << div);
    chk("sampling length", samp_cnt[11:0], 12'h004 << div);
    chk("irq at end", {11'h000, irq_out}, {11'h000, en});
    @(posedge clock_in);
    chk("conversion clocks", clk_cnt[11:0], 12'h010);
    bus_rd(`ACS_ADDR_IRQ_STAT, rd_val);
    chk("irq status set", {4'h0, rd_val}, 12'h001);
    bus_rd(`ACS_ADDR_RES_HIGH, rd_val);
    chk("result high", {4'h0, rd_val}, {8'h00, res[11:8]});
    bus_rd(`ACS_ADDR_RES_LOW, rd_val);
    chk("result low", {4'h0, rd_val}, {4'h0, res[7:0]});
    bus_wr(`ACS_ADDR_IRQ_CLR, 8'h01);
    bus_rd(`ACS_ADDR_IRQ_STAT, rd_val);
    chk("irq status cleared", {4'h0, rd_val}, 12'h000);
    chk("irq dropped", {11'h000, irq_out}, 12'h000);
  endtask : test_conversion

  // Reset in mid-conversion must bring outputs and registers back to zero
  task automatic test_mid_reset();
    bus_wr(`ACS_ADDR_CLKDIV, 8'h07);
    bus_wr(`ACS_ADDR_CTRL, 8'h03);
    repeat (8) @(posedge clock_in);
    bus_wr(`ACS_ADDR_CTRL, 8'h02);
    repeat (20) @(posedge clock_in);
    chk("busy before reset", {11'h000, busy_out}, 12'h001);
    rst_n_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    chk("busy after reset", {11'h000, busy_out}, 12'h000);
    chk("power after reset", {11'h000, power_enable_out}, 12'h000);
    chk("irq after mid reset", {11'h000, irq_out}, 12'h000);
    bus_rd(`ACS_ADDR_CLKDIV, rd_val);
    chk("divider after reset", {4'h0, rd_val}, 12'h000);
  endtask : test_mid_reset

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Watchdog: eight conversions need about 5000 cycles, so 40000 is ample
  initial begin
    #(50 * 40000);
    bad_count++;
    test_done();
  end

  initial begin
    clock_in      = 1'b0;
    rst_n_in      = 1'b0;
    addr_in       = 4'h0;
    wdata_in      = 8'h00;
    wr_in         = 1'b0;
    rd_in         = 1'b0;
    sar_result_in = 12'h000;
    bad_count     = 0;
    checks_done   = 0;
    busy_cnt      = 0;
    samp_cnt      = 0;
    clk_cnt       = 0;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    test_reset_values();
    test_power_off_start();
    test_mid_reset();
    // Every divider code, interrupt enabled on odd codes only; at 20 MHz only
    // codes 4 to 7 keep the recommended period, faster ones just cover the divider
    for (int d = 0; d < 8; d++) begin
      test_conversion(d[2:0], d[0]);
    end
    test_done();
  end
endmodule : acs_sequencer_tb_top
`default_nettype wire

// ===== verilog/acs_clock_divider.sv
`timescale 1ns/100ps
`default_nettype none
// Emits one-cycle tick every 2**select system clocks
module acs_clock_divider (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic [2:0] select_in,
  output logic            tick_out
);
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic       tick_q;
  logic       tick_d;
  logic [6:0] limit;

  // Terminal count; held at zero while idle so each conversion starts aligned
  always_comb begin
    limit   = 7'((8'h01 << select_in) - 8'h01);
    count_d = count_q;
    tick_d  = 1'b0;
    if (!run_in) begin
      count_d = 7'h00;
    end else if (count_q >= limit) begin
      count_d = 7'h00;
      tick_d  = 1'b1;
    end else begin
      count_d = count_q + 7'h01;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 7'h00;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule : acs_clock_divider
`default_nettype wire

// ===== verilog/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_ADDR_CTRL      4'h0
`define ACS_ADDR_CLKDIV    4'h1
`define ACS_ADDR_RES_HIGH  4'h2
`define ACS_ADDR_RES_LOW   4'h3
`define ACS_ADDR_IRQ_STAT  4'h4
`define ACS_ADDR_IRQ_EN    4'h5
`define ACS_ADDR_IRQ_CLR   4'h6
`define ACS_BIT_START      0
`define ACS_BIT_POWER      1
`define ACS_BIT_BUSY       7
`define ACS_SAMPLE_CLKS    5'h04
`define ACS_TOTAL_CLKS     5'h10
`endif

// ===== verilog/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_RESOLVE = 2'b10
  } acs_state_e;
endpackage : acs_pkg

// ===== verilog/acs_sequencer.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.svh"
module acs_sequencer (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [11:0] sar_result_in,
  output logic      [7:0]  rdata_out,
  output logic             irq_out,
  output logic             power_enable_out,
  output logic             sample_out,
  output logic             conversion_clock_out,
  output logic             busy_out
);
  acs_pkg::acs_state_e state_q, state_d;
  logic        start_q, start_d;
  logic        power_q, power_d;
  logic [2:0]  div_q, div_d;
  logic [4:0]  clks_q, clks_d;
  logic        busy_q, busy_d;
  logic [11:0] result_q, result_d;
  logic        stat_q, stat_d;
  logic        ien_q, ien_d;
  logic        irq_q, irq_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        cclk_q, cclk_d;
  logic        sample_q, sample_d;
  logic        tick;
  logic        wr_ctrl;
  logic        start_fall;
  logic        done;

  acs_clock_divider u_div (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .run_in    (busy_d), // Start cycle counts, so busy spans exactly 16 periods
    .select_in (div_q),
    .tick_out  (tick)
  );

  assign wr_ctrl    = wr_in && (addr_in == `ACS_ADDR_CTRL);
  // Start fires on the high-to-low write of the start bit
  assign start_fall = wr_ctrl && start_q && !wdata_in[`ACS_BIT_START];
  assign done       = busy_q && tick && (clks_q == `ACS_TOTAL_CLKS - 5'h01);

  // Control registers and conversion sequence
  always_comb begin
    start_d  = start_q;
    power_d  = power_q;
    div_d    = div_q;
    state_d  = state_q;
    clks_d   = clks_q;
    busy_d   = busy_q;
    result_d = result_q;
    cclk_d   = 1'b0;
    if (wr_ctrl) begin
      start_d = wdata_in[`ACS_BIT_START];
      power_d = wdata_in[`ACS_BIT_POWER];
    end
    if (wr_in && addr_in == `ACS_ADDR_CLKDIV) begin
      div_d = wdata_in[2:0];
    end
    unique case (state_q)
      acs_pkg::ACS_IDLE: begin
        // Ignored while unpowered so busy never rises on a dead converter
        if (start_fall && power_q && wdata_in[`ACS_BIT_POWER]) begin
          state_d = acs_pkg::ACS_SAMPLE;
          busy_d  = 1'b1;
          clks_d  = 5'h00;
        end
      end
      acs_pkg::ACS_SAMPLE: begin
        cclk_d = tick;
        if (tick) begin
          clks_d = clks_q + 5'h01;
          if (clks_q == `ACS_SAMPLE_CLKS - 5'h01) begin
            state_d = acs_pkg::ACS_RESOLVE;
          end
        end
      end
      acs_pkg::ACS_RESOLVE: begin
        cclk_d = tick;
        if (tick) begin
          clks_d = clks_q + 5'h01;
        end
        if (done) begin
          state_d  = acs_pkg::ACS_IDLE;
          busy_d   = 1'b0;
          result_d = sar_result_in;
        end
      end
    endcase
    // Dropping power aborts a conversion with no interrupt; a completion in the same cycle still loads the result
    if (!power_d) begin
      state_d = acs_pkg::ACS_IDLE;
      busy_d  = 1'b0;
    end
    // Registered copy of the sampling state keeps the output glitch free
    sample_d = (state_d == acs_pkg::ACS_SAMPLE);
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_q  <= 1'b0;
      power_q  <= 1'b0;
      div_q    <= 3'h0;
      state_q  <= acs_pkg::ACS_IDLE;
      clks_q   <= 5'h00;
      busy_q   <= 1'b0;
      result_q <= 12'h000;
      cclk_q   <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      start_q  <= start_d;
      power_q  <= power_d;
      div_q    <= div_d;
      state_q  <= state_d;
      clks_q   <= clks_d;
      busy_q   <= busy_d;
      result_q <= result_d;
      cclk_q   <= cclk_d;
      sample_q <= sample_d;
    end
  end

  // Interrupt status: set beats clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    ien_d  = ien_q;
    if (wr_in && addr_in == `ACS_ADDR_IRQ_CLR && wdata_in[0]) begin
      stat_d = 1'b0;
    end
    if (wr_in && addr_in == `ACS_ADDR_IRQ_EN) begin
      ien_d = wdata_in[0];
    end
    if (done && power_d) begin
      stat_d = 1'b1;
    end
    irq_d = stat_d && ien_d;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_q <= 1'b0;
      ien_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      ien_q  <= ien_d;
      irq_q  <= irq_d;
    end
  end

  // Read mux; unmapped addresses and the clear register read zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `ACS_ADDR_CTRL:     rdata_d = {busy_q, 5'h00, power_q, start_q};
        `ACS_ADDR_CLKDIV:   rdata_d = {5'h00, div_q};
        `ACS_ADDR_RES_HIGH: rdata_d = {4'h0, result_q[11:8]};
        `ACS_ADDR_RES_LOW:  rdata_d = result_q[7:0];
        `ACS_ADDR_IRQ_STAT: rdata_d = {7'h00, stat_q};
        `ACS_ADDR_IRQ_EN:   rdata_d = {7'h00, ien_q};
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out            = rdata_q;
  assign irq_out              = irq_q;
  assign power_enable_out     = power_q;
  assign sample_out           = sample_q;
  assign conversion_clock_out = cclk_q;
  assign busy_out             = busy_q;

  // Busy rises one cycle after an accepted start
  start_busy_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_q == acs_pkg::ACS_IDLE && start_fall && power_q && wdata_in[1]) |=> busy_q)
    else $error("busy did not rise after start");

  // Busy holds until completion or power loss
  busy_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (busy_q && !done && power_d) |=> busy_q)
    else $error("busy dropped early");

  // Busy only outside the idle state
  busy_state_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    busy_q |-> state_q != acs_pkg::ACS_IDLE)
    else $error("busy while idle");

  // Idle state always shows busy clear, so polling sees the end
  idle_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_q == acs_pkg::ACS_IDLE |-> !busy_q)
    else $error("busy left set in idle");

  // No busy without power
  nopower_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !power_q |-> !busy_q)
    else $error("busy high while unpowered");

  // Completion clears busy and flags interrupt together
  done_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (done && power_d) |=> (!busy_q && stat_q))
    else $error("end of conversion mishandled");

  // Enabled pending flag shows on interrupt
  irq_level_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (stat_q && ien_q) |-> irq_q)
    else $error("interrupt missing");

  // Interrupt never shows without an enabled pending flag
  irq_match_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    irq_q |-> (stat_q && ien_q))
    else $error("spurious interrupt");

  // Status stays pending until software clears it
  stat_sticky_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (stat_q && !(wr_in && addr_in == `ACS_ADDR_IRQ_CLR && wdata_in[0])) |=> stat_q)
    else $error("status flag lost");

  // A clear with no completion beside it drops the flag
  stat_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `ACS_ADDR_IRQ_CLR && wdata_in[0] && !done) |=> !stat_q)
    else $error("status flag not cleared");

  // Completion happens only after sixteen conversion clocks
  total_count_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    done |-> (clks_q == 5'h0f && state_q == acs_pkg::ACS_RESOLVE))
    else $error("conversion length wrong");

  // The period counter never passes the last conversion clock
  clks_range_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    busy_q |-> clks_q < `ACS_TOTAL_CLKS)
    else $error("period count overran");

  // Sampling starts from count zero; resolve entered only after fourth sampling clock
  sample_len_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_q == acs_pkg::ACS_SAMPLE && $past(state_q) != acs_pkg::ACS_SAMPLE) |->
      clks_q == 5'h00)
    else $error("sampling did not start at zero");

  resolve_entry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_q == acs_pkg::ACS_RESOLVE && $past(state_q) == acs_pkg::ACS_SAMPLE) |->
      clks_q == 5'h04)
    else $error("sampling length wrong");

  // Sampling indication only inside a conversion
  sample_busy_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    sample_out |-> busy_out)
    else $error("sampling outside conversion");

  // Result captured at completion
  result_cap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (done && power_d) |=> result_q == $past(sar_result_in))
    else $error("result not captured");

  // Result stays put between completions, so two byte reads agree
  result_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !done |=> $stable(result_q))
    else $error("result changed without completion");

  // Read data is zero outside the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without read");

  // Divide by one ticks every busy cycle after the first
  div_one_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (busy_q && $past(busy_q) && div_q == 3'h0 && $past(div_q) == 3'h0) |-> tick)
    else $error("divide by one not ticking");

  // Slower codes never tick on two cycles in a row
  tick_gap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (tick && div_q != 3'h0) |=> !tick)
    else $error("divider ticked twice in a row");

  // Dropping power returns the sequence to idle at once
  power_abort_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !power_d |=> (state_q == acs_pkg::ACS_IDLE && !busy_q))
    else $error("conversion kept running unpowered");
endmodule : acs_sequencer
`default_nettype wire
